// [rtl/bee_top.sv]
// bee_top.sv: token-serial boolean equation engine with timers and latches
`timescale 1ns/1ps
`include "bee_defines.svh"
module bee_top #(
	parameter int TOK_DEPTH = 512, // program words
	parameter int TMR_W     = 20   // timer width in bits
)(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        interval_tick,
	input  wire logic [63:0] elem_status,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             trip_result,
	output logic             event_result,
	output logic      [15:0] var_untimed,
	output logic      [15:0] general_variable_timed_output,
	output logic      [15:0] latch_status_bit,
	output logic             eval_done
);
	localparam int PW = $clog2(TOK_DEPTH);
	// ------
	// reset release
	// ------
	logic [1:0] rst_q; // two-stage release of nrst
	logic       rst_n; // synchronous copy used everywhere
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) rst_q <= 2'h0;
		else rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];
	// ------
	// helpers
	// ------
	// sum-of-products step: and binds tighter than or
	function automatic logic [1:0] bee_join(input logic s, input logic p,
		input logic first, input logic jor, input logic v);
		if (first) bee_join = {1'b0, v};
		else if (jor) bee_join = {s | p, v};
		else bee_join = {s, p & v};
	endfunction
	// address region decode, shared by reads and writes
	function automatic bee_pkg::bee_region_t bee_region(input logic [11:0] a);
		if (a[11]) bee_region = bee_pkg::rg_tok;
		else if (a[11:6] == `BEE_PU_PAGE) bee_region = bee_pkg::rg_pu;
		else if (a[11:6] == `BEE_DO_PAGE) bee_region = bee_pkg::rg_do;
		else if (a[11:5] == 7'h00) bee_region = bee_pkg::rg_reg;
		else bee_region = bee_pkg::rg_none;
	endfunction
	// ------
	// memories
	// ------
	bee_pkg::bee_tok_t tok_mem [TOK_DEPTH]; // equation program
	logic [TMR_W-1:0]  pu_dly [16];        // pickup delays in ticks
	logic [TMR_W-1:0]  do_dly [16];        // dropout delays in ticks
	bee_pkg::bee_region_t wr_rg;           // region of current write
	logic [8:0]        bus_ti;             // token index from address
	assign wr_rg = bee_region(reg_addr);
	assign bus_ti = reg_addr[10:2];
	// memories hold data only, so they carry no reset
	always_ff @(posedge core_clk) begin
		if (reg_wr && wr_rg == bee_pkg::rg_tok && 32'(bus_ti) < TOK_DEPTH)
			tok_mem[PW'(bus_ti)] <= bee_pkg::bee_tok_t'(reg_wdata[15:0]);
		if (reg_wr && wr_rg == bee_pkg::rg_pu) pu_dly[reg_addr[5:2]] <= reg_wdata[TMR_W-1:0];
		if (reg_wr && wr_rg == bee_pkg::rg_do) do_dly[reg_addr[5:2]] <= reg_wdata[TMR_W-1:0];
	end
	// ------
	// control registers
	// ------
	logic       run_en, next_run_en;     // evaluation enabled
	logic [4:0] var_cnt, next_var_cnt;   // active variables
	logic [4:0] lat_cnt, next_lat_cnt;   // active latches
	logic       pend, next_pend;         // save request waiting
	logic       wr_reg;                  // write to register page
	logic       start_chk;               // walker takes the request
	bee_pkg::bee_state_t state, next_state;
	assign wr_reg = reg_wr && wr_rg == bee_pkg::rg_reg;
	assign start_chk = state == bee_pkg::st_idle && pend;
	// counts above sixteen are clamped
	always_comb begin
		next_run_en = run_en;
		next_var_cnt = var_cnt;
		next_lat_cnt = lat_cnt;
		// a new request beats the take in the same cycle
		next_pend = pend & ~start_chk;
		if (wr_reg && reg_addr[4:0] == `BEE_CTRL) begin
			next_run_en = reg_wdata[`BEE_CTRL_RUN];
			if (reg_wdata[`BEE_CTRL_COMMIT]) next_pend = 1'b1;
		end
		if (wr_reg && reg_addr[4:0] == `BEE_COUNT) begin
			next_var_cnt = reg_wdata[4] ? `BEE_NUM_VARS : reg_wdata[4:0];
			next_lat_cnt = reg_wdata[12] ? `BEE_NUM_VARS : reg_wdata[12:8];
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_en <= `BEE_RST_RUN;
			var_cnt <= `BEE_RST_COUNT;
			lat_cnt <= `BEE_RST_COUNT;
			pend <= 1'b0;
		end else begin
			run_en <= next_run_en;
			var_cnt <= next_var_cnt;
			lat_cnt <= next_lat_cnt;
			pend <= next_pend;
		end
	end
	// ------
	// walker
	// ------
	bee_pkg::bee_tok_t tk;               // token under the pointer
	logic [PW-1:0] ptr, next_ptr;        // program pointer
	logic [5:0]    eq, next_eq;          // equation index
	logic          s0, p0, s1, p1;       // sum and product, outer and group
	logic          next_s0, next_p0, next_s1, next_p1;
	logic          f0, f1, next_f0, next_f1; // no term yet at each level
	logic          in_g, next_in_g;      // inside a group
	logic          gj, gi, next_gj, next_gi; // group join and inversion
	logic [4:0]    nops, next_nops;      // operands in this equation
	logic [8:0]    tot, next_tot;        // operands in whole program
	logic [49:0]   res, next_res;        // equation results
	logic          chk, next_chk;        // walk is a save check
	logic          valid, next_valid;    // program accepted
	logic [9:0]    usage, next_usage;    // capacity used, tenths of percent
	bee_pkg::bee_err_t err, next_err;
	bee_pkg::bee_err_t fault;            // error seen at this token
	bee_pkg::bee_stat_t snap, prev, next_snap, next_prev, now;
	logic          bitv, opv, gv;        // operand and group values
	logic [1:0]    jv;                   // join result
	logic          done_run;             // results ready to apply
	assign tk = tok_mem[ptr];
	assign done_run = state == bee_pkg::st_done && !chk;
	assign now = '{spare: 14'h0000, evt: event_result, trip: trip_result,
		latch: latch_status_bit, timed: general_variable_timed_output,
		untimed: var_untimed, elem: elem_status};
	always_comb begin
		next_state = state; next_ptr = ptr; next_eq = eq;
		next_s0 = s0; next_p0 = p0; next_s1 = s1; next_p1 = p1;
		next_f0 = f0; next_f1 = f1; next_in_g = in_g; next_gj = gj; next_gi = gi;
		next_nops = nops; next_tot = tot; next_res = res; next_chk = chk;
		next_valid = valid; next_usage = usage; next_err = err;
		next_snap = snap; next_prev = prev;
		fault = bee_pkg::ec_none;
		jv = 2'h0;
		gv = 1'b0;
		// operand value: edge first, inversion after it
		unique case (tk.edge_mode)
			bee_pkg::ed_rise: bitv = snap[tk.sel] & ~prev[tk.sel];
			bee_pkg::ed_fall: bitv = ~snap[tk.sel] & prev[tk.sel];
			default: bitv = snap[tk.sel];
		endcase
		opv = (tk.kind == bee_pkg::tk_c1) ? 1'b1 :
			(tk.kind == bee_pkg::tk_c0) ? 1'b0 : bitv ^ tk.inv;
		unique case (state)
			bee_pkg::st_idle: begin
				if (pend || (interval_tick && valid && run_en)) begin
					next_state = bee_pkg::st_walk;
					next_chk = pend;
					if (pend) begin
						next_valid = 1'b0;
						next_err = bee_pkg::ec_none;
					end else begin
						// every equation reads one frozen snapshot
						next_snap = now;
						next_prev = snap;
					end
					next_ptr = '0; next_eq = 6'h00; next_tot = 9'h000;
					next_f0 = 1'b1; next_in_g = 1'b0; next_nops = 5'h00;
					next_s0 = 1'b0; next_p0 = 1'b0;
				end
			end
			bee_pkg::st_walk: begin
				next_ptr = ptr + PW'(1);
				unique case (tk.kind)
					bee_pkg::tk_bit, bee_pkg::tk_c0, bee_pkg::tk_c1: begin
						next_nops = nops + 5'h01;
						next_tot = tot + 9'h001;
						if (tot == `BEE_MAX_TOT_OPS) fault = bee_pkg::ec_cap;
						else if (nops == `BEE_MAX_EQ_OPS) fault = bee_pkg::ec_ops;
						if (in_g) begin
							jv = bee_join(s1, p1, f1, tk.join_or, opv);
							{next_s1, next_p1} = jv;
							next_f1 = 1'b0;
						end else begin
							jv = bee_join(s0, p0, f0, tk.join_or, opv);
							{next_s0, next_p0} = jv;
							next_f0 = 1'b0;
						end
					end
					bee_pkg::tk_open: begin
						if (in_g) fault = bee_pkg::ec_nest;
						else if (tk.edge_mode != bee_pkg::ed_none) fault = bee_pkg::ec_edge;
						next_in_g = 1'b1;
						next_f1 = 1'b1;
						next_s1 = 1'b0;
						next_p1 = 1'b0;
						next_gj = tk.join_or;
						next_gi = tk.inv;
					end
					bee_pkg::tk_close: begin
						if (!in_g) fault = bee_pkg::ec_bal;
						else if (f1) fault = bee_pkg::ec_blank;
						// group result joins the outer level as one term
						gv = (s1 | p1) ^ gi;
						jv = bee_join(s0, p0, f0, gj, gv);
						{next_s0, next_p0} = jv;
						next_f0 = 1'b0;
						next_in_g = 1'b0;
					end
					bee_pkg::tk_end: begin
						if (in_g) fault = bee_pkg::ec_bal;
						else if (f0) fault = bee_pkg::ec_blank;
						next_res[eq] = s0 | p0;
						next_eq = eq + 6'h01;
						next_f0 = 1'b1;
						next_nops = 5'h00;
						if (eq == `BEE_EQ_LAST) next_state = bee_pkg::st_done;
					end
					default: fault = bee_pkg::ec_tok;
				endcase
				if (fault == bee_pkg::ec_none && 32'(ptr) == TOK_DEPTH - 1 &&
					!(tk.kind == bee_pkg::tk_end && eq == `BEE_EQ_LAST))
					fault = bee_pkg::ec_over;
				// a bad program stops evaluation until saved again
				if (fault != bee_pkg::ec_none) begin
					next_err = fault;
					next_valid = 1'b0;
					next_state = bee_pkg::st_idle;
				end
			end
			bee_pkg::st_done: begin
				next_state = bee_pkg::st_idle;
				if (chk) begin
					next_valid = 1'b1;
					next_usage = 10'((20'(tot) * `BEE_PERMILLE) / 20'(`BEE_MAX_TOT_OPS));
				end
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= bee_pkg::st_idle; ptr <= '0; eq <= 6'h00;
			s0 <= 1'b0; p0 <= 1'b0; s1 <= 1'b0; p1 <= 1'b0;
			f0 <= 1'b1; f1 <= 1'b1; in_g <= 1'b0; gj <= 1'b0; gi <= 1'b0;
			nops <= 5'h00; tot <= 9'h000; res <= '0; chk <= 1'b0;
			valid <= 1'b0; usage <= 10'h000; err <= bee_pkg::ec_none;
			snap <= '0; prev <= '0;
		end else begin
			state <= next_state; ptr <= next_ptr; eq <= next_eq;
			s0 <= next_s0; p0 <= next_p0; s1 <= next_s1; p1 <= next_p1;
			f0 <= next_f0; f1 <= next_f1; in_g <= next_in_g; gj <= next_gj; gi <= next_gi;
			nops <= next_nops; tot <= next_tot; res <= next_res; chk <= next_chk;
			valid <= next_valid; usage <= next_usage; err <= next_err;
			snap <= next_snap; prev <= next_prev;
		end
	end
	// ------
	// results, timers and latches
	// ------
	logic [TMR_W-1:0] pcnt [16], next_pcnt [16]; // pickup counters
	logic [TMR_W-1:0] dcnt [16], next_dcnt [16]; // dropout counters
	logic             next_trip, next_evt, next_done;
	logic [15:0]      next_unt, next_tmd, next_lat;
	// outputs move only when a run walk completes or the latch register is written
	always_comb begin
		next_trip = trip_result; next_evt = event_result;
		next_unt = var_untimed; next_tmd = general_variable_timed_output;
		next_lat = latch_status_bit;
		next_done = done_run;
		next_pcnt = pcnt; next_dcnt = dcnt;
		// reload from the outside store
		if (wr_reg && reg_addr[4:0] == `BEE_LATCH) next_lat = reg_wdata[15:0];
		if (done_run) begin
			next_trip = res[`BEE_EQ_TRIP];
			next_evt = res[`BEE_EQ_EVT];
			for (int i = 0; i < 16; i++) begin
				if (5'(i) < var_cnt) begin
					next_unt[i] = res[`BEE_EQ_VAR + i];
					if (res[`BEE_EQ_VAR + i]) begin
						next_dcnt[i] = '0;
						if (!general_variable_timed_output[i]) begin
							if (pcnt[i] >= pu_dly[i]) next_tmd[i] = 1'b1;
							else next_pcnt[i] = pcnt[i] + TMR_W'(1);
						end
					end else begin
						next_pcnt[i] = '0;
						if (general_variable_timed_output[i]) begin
							if (dcnt[i] >= do_dly[i]) next_tmd[i] = 1'b0;
							else next_dcnt[i] = dcnt[i] + TMR_W'(1);
						end
					end
				end else begin
					next_unt[i] = 1'b0;
					next_tmd[i] = 1'b0;
					next_pcnt[i] = '0;
					next_dcnt[i] = '0;
				end
				// disabled latches keep their state
				if (5'(i) < lat_cnt) begin
					if (res[`BEE_EQ_CLR + i]) next_lat[i] = 1'b0;
					else if (res[`BEE_EQ_SET + i]) next_lat[i] = 1'b1;
				end
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trip_result <= 1'b0; event_result <= 1'b0; eval_done <= 1'b0;
			var_untimed <= 16'h0000; general_variable_timed_output <= 16'h0000;
			latch_status_bit <= 16'h0000;
			for (int i = 0; i < 16; i++) begin
				pcnt[i] <= '0;
				dcnt[i] <= '0;
			end
		end else begin
			trip_result <= next_trip; event_result <= next_evt; eval_done <= next_done;
			var_untimed <= next_unt; general_variable_timed_output <= next_tmd;
			latch_status_bit <= next_lat;
			pcnt <= next_pcnt;
			dcnt <= next_dcnt;
		end
	end
	// ------
	// read port
	// ------
	logic [31:0] next_rdata; // data shown the cycle after the strobe
	bee_pkg::bee_region_t rd_rg;
	assign rd_rg = bee_region(reg_addr);
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (rd_rg)
				bee_pkg::rg_tok: if (32'(bus_ti) < TOK_DEPTH) next_rdata = {16'h0000, tok_mem[PW'(bus_ti)]};
				bee_pkg::rg_pu: next_rdata = 32'(pu_dly[reg_addr[5:2]]);
				bee_pkg::rg_do: next_rdata = 32'(do_dly[reg_addr[5:2]]);
				bee_pkg::rg_reg: begin
					unique case (reg_addr[4:0])
						`BEE_CTRL: next_rdata = {30'h0, run_en, 1'b0};
						`BEE_STAT: next_rdata = {24'h0, err, 1'b0, run_en, state != bee_pkg::st_idle, valid};
						`BEE_COUNT: next_rdata = {19'h0, lat_cnt, 3'h0, var_cnt};
						`BEE_USAGE: next_rdata = {22'h0, usage};
						`BEE_OUTS: next_rdata = {30'h0, event_result, trip_result};
						`BEE_VARS: next_rdata = {general_variable_timed_output, var_untimed};
						`BEE_LATCH: next_rdata = {16'h0000, latch_status_bit};
						`BEE_OPS: next_rdata = {23'h0, tot};
						default: next_rdata = 32'h0000_0000;
					endcase
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) reg_rdata <= 32'h0000_0000;
		else reg_rdata <= next_rdata;
	end
	// ------
	// checks
	// ------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic walk; // walker is reading tokens
	assign walk = state == bee_pkg::st_walk;
	property p_blank;
		walk && tk.kind == bee_pkg::tk_end && !in_g && f0 |=> !valid && err == bee_pkg::ec_blank;
	endproperty
	a_blank: assert property (p_blank) else $error("blank equation accepted");
	property p_nest;
		walk && tk.kind == bee_pkg::tk_open && in_g |=>
			state == bee_pkg::st_idle && err == bee_pkg::ec_nest;
	endproperty
	a_nest: assert property (p_nest) else $error("nested group accepted");
	property p_edge_grp;
		walk && tk.kind == bee_pkg::tk_open && !in_g && tk.edge_mode != bee_pkg::ed_none |=>
			err == bee_pkg::ec_edge;
	endproperty
	a_edge_grp: assert property (p_edge_grp) else $error("edge on group accepted");
	property p_eq_ops;
		walk && (tk.kind == bee_pkg::tk_bit) && nops == `BEE_MAX_EQ_OPS &&
			tot != `BEE_MAX_TOT_OPS |=> err == bee_pkg::ec_ops && !valid;
	endproperty
	a_eq_ops: assert property (p_eq_ops) else $error("too many operands accepted");
	property p_total;
		valid |-> tot <= `BEE_MAX_TOT_OPS;
	endproperty
	a_total: assert property (p_total) else $error("capacity exceeded while valid");
	property p_order;
		walk ##1 walk |-> eq >= $past(eq);
	endproperty
	a_order: assert property (p_order) else $error("equation order went back");
	property p_clr_wins;
		done_run && lat_cnt != 5'h00 && res[`BEE_EQ_CLR] && res[`BEE_EQ_SET] |=> !latch_status_bit[0];
	endproperty
	a_clr_wins: assert property (p_clr_wins) else $error("latch set won over clear");
	property p_untimed;
		done_run |=> var_untimed[0] == $past(res[`BEE_EQ_VAR] && var_cnt != 5'h00);
	endproperty
	a_untimed: assert property (p_untimed) else $error("untimed bit differs from result");
	property p_pickup;
		$rose(general_variable_timed_output[0]) |-> var_untimed[0] && $past(done_run);
	endproperty
	a_pickup: assert property (p_pickup) else $error("timed output rose without result");
	property p_dropout;
		$fell(general_variable_timed_output[0]) |-> !var_untimed[0];
	endproperty
	a_dropout: assert property (p_dropout) else $error("timed output fell while result high");
	property p_quiet;
		!done_run |=> $stable(trip_result) && $stable(var_untimed);
	endproperty
	a_quiet: assert property (p_quiet) else $error("output moved outside an update");
	c_saved: cover property (state == bee_pkg::st_done && chk ##1 valid);
	c_latch: cover property ($rose(latch_status_bit[0]));
	c_timed: cover property ($rose(general_variable_timed_output[0]));
	c_error: cover property (walk ##1 err != bee_pkg::ec_none);
endmodule

// [shared/bee_defines.svh]
// bee_defines.svh: register map, limits and reset values of the equation engine
`ifndef BEE_DEFINES_SVH
`define BEE_DEFINES_SVH
// ------
// register offsets (byte addresses) and delay table pages (address bits 11:6)
// ------
`define BEE_CTRL     12'h000
`define BEE_STAT     12'h004
`define BEE_COUNT    12'h008
`define BEE_USAGE    12'h00c
`define BEE_OUTS     12'h010
`define BEE_VARS     12'h014
`define BEE_LATCH    12'h018
`define BEE_OPS      12'h01c
`define BEE_PU_PAGE  6'h04
`define BEE_DO_PAGE  6'h05
// ------
// field positions
// ------
`define BEE_CTRL_COMMIT 0
`define BEE_CTRL_RUN    1
`define BEE_CNT_LAT_LSB 8
`define BEE_STAT_ERR    4
// ------
// limits and reset values
// ------
`define BEE_MAX_EQ_OPS  5'h11
`define BEE_MAX_TOT_OPS 9'h14a
`define BEE_PERMILLE    20'h003e8
`define BEE_NUM_VARS    5'h10
`define BEE_EQ_TRIP     0
`define BEE_EQ_EVT      1
`define BEE_EQ_VAR      2
`define BEE_EQ_SET      18
`define BEE_EQ_CLR      34
`define BEE_EQ_LAST     6'h31
`define BEE_RST_COUNT   5'h00
`define BEE_RST_RUN     1'b0
`endif

// [shared/bee_pkg.sv]
// bee_pkg.sv: types shared by the equation engine
package bee_pkg;
	// token kinds; codes 6 and 7 are illegal
	typedef enum logic [2:0] {tk_end, tk_bit, tk_c0, tk_c1, tk_open, tk_close} bee_kind_t;
	// edge modifier on an operand
	typedef enum logic [1:0] {ed_none, ed_rise, ed_fall} bee_edge_t;
	// one program token, one per memory word
	typedef struct packed {
		bee_kind_t   kind;    // what the token is
		logic        join_or; // joined to the left by or, else and
		logic        inv;     // inversion of operand or group
		bee_edge_t   edge_mode; // edge detect on a bit
		logic [1:0]  spare;   // unused, keep zero
		logic [6:0]  sel;     // status bit index
	} bee_tok_t;
	// status word seen by the equations
	typedef struct packed {
		logic [13:0] spare;
		logic        evt;
		logic        trip;
		logic [15:0] latch;
		logic [15:0] timed;
		logic [15:0] untimed;
		logic [63:0] elem;
	} bee_stat_t;
	// walk errors
	typedef enum logic [3:0] {ec_none, ec_blank, ec_nest, ec_edge, ec_ops, ec_cap,
		ec_bal, ec_over, ec_tok} bee_err_t;
	// walker states
	typedef enum logic [1:0] {st_idle, st_walk, st_done} bee_state_t;
	// bus regions
	typedef enum logic [2:0] {rg_none, rg_reg, rg_pu, rg_do, rg_tok} bee_region_t;
endpackage

// [sim/bee_elem_src.sv]
// bee_elem_src.sv: behavioural source of element status bits and interval ticks
`timescale 1ns/1ps
module bee_elem_src (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [63:0] next_bits,
	input  wire logic        fire,
	output logic      [63:0] elem_status,
	output logic             interval_tick
);
	// ------
	// element levels and tick
	// ------
	// new levels land with the tick, so every run sees a settled snapshot
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			elem_status   <= 64'h0;
			interval_tick <= 1'b0;
		end else begin
			interval_tick <= fire;
			// levels hold between ticks, like real element outputs
			if (fire) begin
				elem_status <= next_bits;
			end
		end
	end
endmodule

// [sim/test_boolean_equation_engine.sv]
// test_boolean_equation_engine.sv: self-checking bench of the equation engine
`timescale 1ns/1ps
`include "bee_defines.svh"
module test_boolean_equation_engine;
	// ------
	// signals
	// ------
	logic        core_clk;
	logic        nrst;
	logic        interval_tick;
	logic [63:0] elem_status;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        trip_result;
	logic        event_result;
	logic [15:0] var_untimed;
	logic [15:0] general_variable_timed_output;
	logic [15:0] latch_status_bit;
	logic        eval_done;
	logic [63:0] next_bits; // levels for the next tick
	logic        fire;      // ask the source for a tick
	int          bad_count;
	int          cmp_count;

	bee_top i_bee_top (.core_clk(core_clk), .nrst(nrst), .interval_tick(interval_tick),
		.elem_status(elem_status), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trip_result(trip_result), .event_result(event_result), .var_untimed(var_untimed),
		.general_variable_timed_output(general_variable_timed_output),
		.latch_status_bit(latch_status_bit), .eval_done(eval_done));
	bee_elem_src i_bee_elem_src (.core_clk(core_clk), .nrst(nrst), .next_bits(next_bits),
		.fire(fire), .elem_status(elem_status), .interval_tick(interval_tick));

	// ------
	// clock and watchdog
	// ------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// whole run is a few thousand cycles; this bound is generous
	initial begin
		#400000;
		bad_count++;
		results();
	end

	// ------
	// tasks
	// ------
	task automatic results();
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// load a token program, request a save walk and judge the status word
	task automatic commit(input logic [15:0] p[$], input logic [31:0] exp);
		logic [31:0] st;
		int          n;
		foreach (p[i]) wr(12'h800 + 12'(i * 4), {16'h0, p[i]});
		wr(`BEE_CTRL, 32'h3);
		repeat (3) @(posedge core_clk);
		n = 0;
		rd(`BEE_STAT, st);
		while (st[1] !== 1'b0 && n < 600) begin
			rd(`BEE_STAT, st);
			n++;
		end
		chk(st & 32'hf3, exp);
	endtask
	// one interval: new levels plus tick, then outputs after the done pulse
	task automatic run_step(input logic [27:0] r);
		int n;
		@(posedge core_clk);
		next_bits <= {56'h0, r[27:20]};
		fire      <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		n = 0;
		#1;
		while (eval_done !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		// a missing done pulse means the run hung
		chk({31'h0, eval_done}, 32'h1);
		chk({31'h0, trip_result}, {31'h0, r[16]});
		chk({31'h0, event_result}, {31'h0, r[12]});
		chk({16'h0, var_untimed}, {29'h0, r[10:8]});
		chk({16'h0, general_variable_timed_output}, {29'h0, r[6:4]});
		chk({16'h0, latch_status_bit}, {31'h0, r[0]});
	endtask

	// ------
	// main sequence
	// ------
	initial begin
		logic [31:0] st;
		logic [15:0] q[$];
		// levels, then trip, event, untimed, timed, latch of each interval
		logic [27:0] tab[9];
		tab = '{28'h0800440, 28'h3111750, 28'h3500640, 28'h4210441,
			28'h2000641, 28'h2000641, 28'h2000661, 28'hc000460, 28'h0000440};
		nrst      = 1'b0;
		reg_addr  = 12'h0;
		reg_wdata = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		next_bits = 64'h0;
		fire      = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk({14'h0, trip_result, event_result, var_untimed}, 32'h0);
		chk({general_variable_timed_output, latch_status_bit}, 32'h0);
		rd(`BEE_COUNT, st);
		chk(st, 32'h0);
		wr(`BEE_COUNT, 32'h103);
		rd(`BEE_COUNT, st);
		chk(st, 32'h103);
		for (int i = 0; i < 3; i++) begin
			wr(12'h100 + 12'(i * 4), (i == 1) ? 32'h2 : 32'h0);
			wr(12'h140 + 12'(i * 4), (i == 1) ? 32'h1 : 32'h0);
		end
		rd(12'h104, st);
		chk(st, 32'h2);
		q = '{16'h0000};
		commit(q, 32'h10);
		q = '{16'h8000, 16'h8000, 16'h2000, 16'ha000, 16'ha000, 16'h0000};
		commit(q, 32'h20);
		q = '{16'h8400, 16'h2000, 16'ha000, 16'h0000};
		commit(q, 32'h30);
		q = {};
		for (int i = 0; i < 18; i++) q.push_back(16'h3000 | 16'(i));
		q.push_back(16'h0000);
		commit(q, 32'h40);
		q = {};
		for (int i = 0; i < 306; i++) q.push_back((i % 17 == 16) ? 16'h3000 : 16'h3001);
		for (int i = 0; i < 18; i++) q.insert(18 * i + 17, 16'h0000);
		for (int i = 0; i < 32; i++) q = {q, 16'h4000, 16'h0000};
		commit(q, 32'h50);
		// group left open at the end of the equation
		q = '{16'h8000, 16'h2000, 16'h0000};
		commit(q, 32'h60);
		// trip (e0+e1)*!(e2), event fall e3, var0 rise e4, var1 e5, var2 and var3 one
		q = '{16'h8000, 16'h2000, 16'h3001, 16'ha000, 16'h8800, 16'h2002, 16'ha000,
			16'h0000, 16'h2403, 16'h0000, 16'h2204, 16'h0000, 16'h2005, 16'h0000,
			16'h6000, 16'h0000, 16'h6000, 16'h0000};
		for (int i = 0; i < 12; i++) q = {q, 16'h4000, 16'h0000};
		q = {q, 16'h2006, 16'h0000};
		for (int i = 0; i < 15; i++) q = {q, 16'h4000, 16'h0000};
		q = {q, 16'h2007, 16'h0000};
		for (int i = 0; i < 15; i++) q = {q, 16'h4000, 16'h0000};
		commit(q, 32'h1);
		rd(`BEE_USAGE, st);
		chk(st, 32'h9d);
		rd(`BEE_OPS, st);
		chk(st, 32'h34);
		rd(12'h020, st);
		chk(st, 32'h0);
		wr(`BEE_LATCH, 32'h8001);
		rd(`BEE_LATCH, st);
		chk(st, 32'h8001);
		wr(`BEE_LATCH, 32'h0);
		foreach (tab[i]) run_step(tab[i]);
		rd(`BEE_VARS, st);
		chk(st, 32'h0004_0004);
		rd(`BEE_OUTS, st);
		chk(st, 32'h0);
		results();
	end
endmodule
